/* ccpu_edge_presc.sv */
// capture edge detector and edge prescaler
`timescale 1ns/10ps
module ccpu_edge_presc (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       reset,
   // control
   input  wire logic       clear,
   input  wire logic [1:0] edge_sel,
   input  wire logic       pin,
   // result
   output logic            capture_evt,
   output logic [3:0]      presc_count
);

   typedef struct packed {
      logic       pin_q;
      logic [3:0] cnt_q;
      logic       evt_q;
   } ccpu_presc_s;

   ccpu_presc_s st_q;
   ccpu_presc_s st_d;

   // =========================================================
   // next state: edge select and prescale count
   always_comb begin
      logic rise;
      logic fall;
      rise = pin & ~st_q.pin_q;
      fall = ~pin & st_q.pin_q;
      st_d = st_q;
      st_d.pin_q = pin;
      st_d.evt_q = 1'b0;
      if (clear) begin
         st_d.cnt_q = 4'h0;
      end else begin
         case (edge_sel)
            2'd0: st_d.evt_q = fall;
            2'd1: st_d.evt_q = rise;
            default: begin
               // a switch between 4 and 16 keeps the count
               if (rise) begin
                  if (st_q.cnt_q == ((edge_sel == 2'd2) ? ccpu_pkg::PRESC_LAST_4
                                                       : ccpu_pkg::PRESC_LAST_16)) begin
                     st_d.cnt_q = 4'h0;
                     st_d.evt_q = 1'b1;
                  end else begin
                     st_d.cnt_q = st_q.cnt_q + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   // =========================================================
   // state register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign capture_evt = st_q.evt_q;
   assign presc_count = st_q.cnt_q;

endmodule

/* ccpu_pkg.sv */
// package: register map, mode codes and reset values of the capture/compare/pwm unit
package ccpu_pkg;

   // =========================================================
   // register map (index on the register port)
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_VAL_LO  = 4'h1;
   localparam logic [3:0] OFS_VAL_HI  = 4'h2;
   localparam logic [3:0] OFS_PERIOD  = 4'h3;
   localparam logic [3:0] OFS_IRQ_EN  = 4'h4;
   localparam logic [3:0] OFS_IRQ_FLG = 4'h5;
   localparam logic [3:0] OFS_STATUS  = 4'h6;

   // =========================================================
   // control field layout
   localparam int MODE_LSB = 0;
   localparam int DUTY_LSB = 4;

   // =========================================================
   // reset values
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_PERIOD  = 8'hFF;
   localparam logic [7:0] RST_VALUE   = 8'h00;

   // =========================================================
   // mode field codes
   localparam logic [3:0] MODE_OFF     = 4'h0;
   localparam logic [3:0] MODE_CAP_FAL = 4'h4;
   localparam logic [3:0] MODE_CAP_RIS = 4'h5;
   localparam logic [3:0] MODE_CAP_4   = 4'h6;
   localparam logic [3:0] MODE_CAP_16  = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] MODE_CMP_SW  = 4'hA;
   localparam logic [3:0] MODE_CMP_SPC = 4'hB;

   // =========================================================
   // edge prescaler counts (last count before an event)
   localparam logic [3:0] PRESC_LAST_4  = 4'h3;
   localparam logic [3:0] PRESC_LAST_16 = 4'hF;

   typedef enum logic [1:0] {
      CLS_OFF,
      CLS_CAPTURE,
      CLS_COMPARE,
      CLS_PWM
   } ccpu_class_e;

endpackage

/* ccpu_timers_model.sv */
// model of the on-chip timebase and period timer feeding the unit
`timescale 1ns/10ps
module ccpu_timers_model (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // bench control
   input  wire logic        run,
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   input  wire logic [7:0]  limit,
   // strobes from the unit
   input  wire logic        tb_clear,
   input  wire logic        pt_clear,
   // timer values
   output logic      [15:0] timebase,
   output logic      [7:0]  ptimer,
   output logic      [1:0]  psub,
   output logic             ptick,
   output logic             ovf
);
   // tick on the last quarter; no postscaler sits in this path
   assign ptick = psub == 2'h3;
   // counts on mclk only, so the unit always sees a synchronous timebase
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         timebase <= 16'h0000;
         ovf      <= 1'b0;
      end else if (load) begin
         timebase <= load_val;
      end else if (tb_clear) begin
         timebase <= 16'h0000;
      end else if (run) begin
         timebase <= timebase + 16'h0001;
         ovf      <= ovf | (timebase == 16'hFFFF);
      end
   end
   // period timer wraps after the limit, one count per four clocks
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ptimer <= 8'h00;
         psub   <= 2'h0;
      end else begin
         psub <= psub + 2'h1;
         if (pt_clear) begin
            ptimer <= 8'h00;
         end else if (ptick) begin
            ptimer <= (ptimer == limit) ? 8'h00 : ptimer + 8'h01;
         end
      end
   end
endmodule

/* ccpu_unit.sv */
// capture, compare and pwm unit with its register port
`timescale 1ns/10ps

// Behaviour
// - mode change may raise false capture flag
// - prescaler held at zero unless capturing
// - prescale switch keeps count; turn off first
// - compare match sets flag; set/clear modes drive pin
// - zero control write forces compare latch low
// - software compare mode: flag only, pin untouched
// - special event on first unit clears timebase
// - second unit also starts conversion if enabled
// - special event clear sets no overflow flag
// - pwm up to ten bits, zero forces low
// - period comes from period limit register
// - period match: clear timer, set pin, latch
// - postscaler takes no part in pwm period
// - duty is low byte plus control bits 5:4
// - duty double buffered, high byte read-only
// - clear pin when duty equals extended timer
// - duty beyond period keeps output high
// - four-bit mode field decode
// - capture copies timebase, sets flag, overwrites
module ccpu_unit #(
   parameter bit IS_SECOND_UNIT = 1'b0,
   parameter bit SINGLE_UNIT    = 1'b0
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // sixteen bit timebase
   input  wire logic [15:0] sixteen_bit_timebase,
   output logic             timebase_clear,
   // eight bit period timer
   input  wire logic [7:0]  period_timer,
   input  wire logic [1:0]  period_sub,
   input  wire logic        period_tick,
   output logic             period_timer_clear,
   // converter
   input  wire logic        adc_enabled,
   output logic             conv_start,
   // unit signal pin and interrupt
   input  wire logic        unit_signal_pin_in,
   output logic             unit_signal_pin_out,
   output logic             unit_irq_request
);

   typedef struct packed {
      logic [5:0] ctrl_q;
      logic [7:0] val_lo_q;
      logic [7:0] val_hi_q;
      logic [1:0] duty_lsb_q;
      logic [7:0] period_limit_q;
      logic       irq_en_q;
      logic       irq_flag_q;
      logic       out_latch_q;
      logic       match_q;
      logic       tb_clr_q;
      logic       pt_clr_q;
      logic       conv_q;
      logic [7:0] rdata_q;
   } ccpu_state_s;

   ccpu_state_s st_q;
   ccpu_state_s st_d;

   logic                capture_evt;
   logic [3:0]          presc_count;
   logic [3:0]          unit_mode_field;
   ccpu_pkg::ccpu_class_e mode_cls;
   logic                presc_clear;

   // =========================================================
   // mode decode, shared by the prescaler and the main logic
   function automatic ccpu_pkg::ccpu_class_e mode_class(input logic [3:0] m);
      if (m[3:2] == 2'b11) begin
         mode_class = ccpu_pkg::CLS_PWM;
      end else if (m[3]) begin
         mode_class = ccpu_pkg::CLS_COMPARE;
      end else if (m[2]) begin
         mode_class = ccpu_pkg::CLS_CAPTURE;
      end else begin
         mode_class = ccpu_pkg::CLS_OFF;
      end
   endfunction

   assign unit_mode_field = st_q.ctrl_q[ccpu_pkg::MODE_LSB +: 4];
   assign mode_cls        = mode_class(unit_mode_field);
   // counter only runs in capture mode
   assign presc_clear     = (mode_cls != ccpu_pkg::CLS_CAPTURE);

   // =========================================================
   // capture edge prescaler
   ccpu_edge_presc u_presc (
      .mclk        (mclk),
      .reset       (reset),
      .clear       (presc_clear),
      .edge_sel    (unit_mode_field[1:0]),
      .pin         (unit_signal_pin_in),
      .capture_evt (capture_evt),
      .presc_count (presc_count)
   );

   // =========================================================
   // next state of the whole unit
   always_comb begin
      logic        match_now;
      logic        match_rise;
      logic        flag_set;
      logic        flag_clr;
      logic [9:0]  duty_active;
      logic [9:0]  timer_ext;
      logic [9:0]  duty_buf;
      match_now   = (sixteen_bit_timebase == {st_q.val_hi_q, st_q.val_lo_q});
      match_rise  = match_now & ~st_q.match_q;
      flag_set    = 1'b0;
      flag_clr    = 1'b0;
      duty_active = {st_q.val_hi_q, st_q.duty_lsb_q};
      timer_ext   = {period_timer, period_sub};
      duty_buf    = {st_q.val_lo_q, st_q.ctrl_q[ccpu_pkg::DUTY_LSB +: 2]};
      st_d = st_q;
      st_d.match_q  = match_now;
      st_d.tb_clr_q = 1'b0;
      st_d.pt_clr_q = 1'b0;
      st_d.conv_q   = 1'b0;
      st_d.rdata_q  = 8'h00;

      // register writes
      if (reg_wr) begin
         if (reg_addr == ccpu_pkg::OFS_CONTROL) begin
            st_d.ctrl_q = reg_wdata[5:0];
         end else if (reg_addr == ccpu_pkg::OFS_VAL_LO) begin
            st_d.val_lo_q = reg_wdata;
         end else if (reg_addr == ccpu_pkg::OFS_VAL_HI) begin
            // active duty byte cannot be written while in pwm
            if (mode_cls != ccpu_pkg::CLS_PWM) begin
               st_d.val_hi_q = reg_wdata;
            end
         end else if (reg_addr == ccpu_pkg::OFS_PERIOD) begin
            st_d.period_limit_q = reg_wdata;
         end else if (reg_addr == ccpu_pkg::OFS_IRQ_EN) begin
            st_d.irq_en_q = reg_wdata[0];
         end else if (reg_addr == ccpu_pkg::OFS_IRQ_FLG) begin
            flag_clr = reg_wdata[0];
         end
      end

      // mode behaviour
      case (mode_cls)
         ccpu_pkg::CLS_CAPTURE: begin
            // an unread value is simply overwritten
            if (capture_evt) begin
               st_d.val_hi_q = sixteen_bit_timebase[15:8];
               st_d.val_lo_q = sixteen_bit_timebase[7:0];
               flag_set      = 1'b1;
            end
         end
         ccpu_pkg::CLS_COMPARE: begin
            // act once per match, not every cycle the timer rests on it
            if (match_rise) begin
               flag_set = 1'b1;
               if (unit_mode_field == ccpu_pkg::MODE_CMP_SET) begin
                  st_d.out_latch_q = 1'b1;
               end else if (unit_mode_field == ccpu_pkg::MODE_CMP_CLR) begin
                  st_d.out_latch_q = 1'b0;
               end else if (unit_mode_field == ccpu_pkg::MODE_CMP_SPC) begin
                  // plain clear strobe: overflow flag stays untouched
                  st_d.tb_clr_q = 1'b1;
                  st_d.conv_q   = adc_enabled & (IS_SECOND_UNIT | SINGLE_UNIT);
               end
               // software mode leaves the latch as it is
            end
         end
         ccpu_pkg::CLS_PWM: begin
            // tick is the prescaled increment, before any postscaler
            if (period_tick && (period_timer == st_q.period_limit_q)) begin
               st_d.pt_clr_q    = 1'b1;
               st_d.out_latch_q = (duty_buf != 10'h000);
               st_d.val_hi_q    = st_q.val_lo_q;
               st_d.duty_lsb_q  = st_q.ctrl_q[ccpu_pkg::DUTY_LSB +: 2];
            end else if (duty_active == timer_ext) begin
               // a duty past the period never matches here
               st_d.out_latch_q = 1'b0;
            end
         end
         default: begin
            st_d.out_latch_q = 1'b0;
         end
      endcase

      // a zero control write beats a match in the same cycle, so the pin never blips high
      if (reg_wr && (reg_addr == ccpu_pkg::OFS_CONTROL) && (reg_wdata[5:0] == 6'h00)) begin
         st_d.out_latch_q = 1'b0;
      end

      // set wins over a clear in the same cycle
      st_d.irq_flag_q = (st_q.irq_flag_q & ~flag_clr) | flag_set;

      // read data, valid the cycle after the strobe
      if (reg_rd) begin
         if (reg_addr == ccpu_pkg::OFS_CONTROL) begin
            st_d.rdata_q = {2'b00, st_q.ctrl_q};
         end else if (reg_addr == ccpu_pkg::OFS_VAL_LO) begin
            st_d.rdata_q = st_q.val_lo_q;
         end else if (reg_addr == ccpu_pkg::OFS_VAL_HI) begin
            st_d.rdata_q = st_q.val_hi_q;
         end else if (reg_addr == ccpu_pkg::OFS_PERIOD) begin
            st_d.rdata_q = st_q.period_limit_q;
         end else if (reg_addr == ccpu_pkg::OFS_IRQ_EN) begin
            st_d.rdata_q = {7'h00, st_q.irq_en_q};
         end else if (reg_addr == ccpu_pkg::OFS_IRQ_FLG) begin
            st_d.rdata_q = {7'h00, st_q.irq_flag_q};
         end else if (reg_addr == ccpu_pkg::OFS_STATUS) begin
            st_d.rdata_q = {presc_count, 3'h0, st_q.out_latch_q};
         end else begin
            st_d.rdata_q = 8'h00;
         end
      end
   end

   // =========================================================
   // state register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_q                <= '0;
         st_q.ctrl_q         <= ccpu_pkg::RST_CONTROL[5:0];
         st_q.val_lo_q       <= ccpu_pkg::RST_VALUE;
         st_q.val_hi_q       <= ccpu_pkg::RST_VALUE;
         st_q.period_limit_q <= ccpu_pkg::RST_PERIOD;
      end else begin
         st_q <= st_d;
      end
   end

   // =========================================================
   // outputs, all from flip-flops except the interrupt gate
   assign reg_rdata           = st_q.rdata_q;
   assign timebase_clear      = st_q.tb_clr_q;
   assign period_timer_clear  = st_q.pt_clr_q;
   assign conv_start          = st_q.conv_q;
   assign unit_signal_pin_out = st_q.out_latch_q;
   assign unit_irq_request    = st_q.irq_flag_q & st_q.irq_en_q;

endmodule

/* ccpu_unit_props.sv */
// concurrent checks on the ports of the capture/compare/pwm unit
`timescale 1ns/10ps
module ccpu_unit_props (
   // clock and reset
   input wire logic        mclk,
   input wire logic        reset,
   // register port
   input wire logic [3:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   // timers, converter and pin
   input wire logic [15:0] sixteen_bit_timebase,
   input wire logic        timebase_clear,
   input wire logic [7:0]  period_timer,
   input wire logic        period_tick,
   input wire logic        period_timer_clear,
   input wire logic        adc_enabled,
   input wire logic        conv_start,
   input wire logic        unit_signal_pin_out
);
   logic [3:0] mode_q;
   logic [7:0] lim_q, lo_q, hi_q;
   logic [1:0] lsb_q;
   wire eq  = sixteen_bit_timebase == {hi_q, lo_q};
   wire pwm = mode_q[3:2] == 2'b11;
   wire pm  = pwm && period_tick && period_timer == lim_q;
   // mirror of software writes; the high byte is left alone in pwm, where it is read-only
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         {lsb_q, mode_q} <= 6'h00;
         lim_q <= 8'hFF;
         {hi_q, lo_q} <= 16'h0000;
      end else if (reg_wr) begin
         case (reg_addr)
            4'h0: {lsb_q, mode_q} <= reg_wdata[5:0];
            4'h1: lo_q <= reg_wdata;
            4'h2: hi_q <= pwm ? hi_q : reg_wdata;
            4'h3: lim_q <= reg_wdata;
            default: ;
         endcase
      end
   end
   // ======================================
   // properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // a match counts once, on the first cycle of equality in a settled mode
   sequence s_hit(m);
      mode_q == m && $past(mode_q) == m && eq && !$past(eq);
   endsequence
   property p_cmp_set; s_hit(4'h8) |=> unit_signal_pin_out; endproperty
   a_cmp_set: assert property (p_cmp_set)
      else $error("pin not set on match");
   property p_cmp_clr; s_hit(4'h9) |=> !unit_signal_pin_out; endproperty
   a_cmp_clr: assert property (p_cmp_clr)
      else $error("pin not cleared on match");
   property p_cmp_sw;
      mode_q == 4'hA && $past(mode_q) == 4'hA |=> $stable(unit_signal_pin_out);
   endproperty
   a_cmp_sw: assert property (p_cmp_sw)
      else $error("pin moved in flag-only mode");
   property p_spc; s_hit(4'hB) |=> timebase_clear; endproperty
   a_spc: assert property (p_spc)
      else $error("no timebase clear on special event");
   property p_tbc_src; timebase_clear |-> $past(mode_q) == 4'hB && $past(eq); endproperty
   a_tbc_src: assert property (p_tbc_src)
      else $error("timebase clear without special event");
   property p_conv; conv_start |-> timebase_clear && $past(adc_enabled); endproperty
   a_conv: assert property (p_conv)
      else $error("conversion start without cause");
   property p_off;
      mode_q == 4'h0 && $past(mode_q) == 4'h0 |-> !unit_signal_pin_out;
   endproperty
   a_off: assert property (p_off)
      else $error("output latch high while off");
   property p_per; pm && $past(pwm) |=> period_timer_clear; endproperty
   a_per: assert property (p_per)
      else $error("no period timer clear at period match");
   property p_ptc_src; period_timer_clear |-> $past(pm); endproperty
   a_ptc_src: assert property (p_ptc_src)
      else $error("period timer clear without match");
   property p_pwm_set;
      pm && $past(pwm) && {lo_q, lsb_q} != 10'h000 |=> unit_signal_pin_out;
   endproperty
   a_pwm_set: assert property (p_pwm_set)
      else $error("pwm output not set at period start");
   c_spc: cover property (timebase_clear);
   c_pwm: cover property (period_timer_clear ##1 unit_signal_pin_out);
   c_fall: cover property (pwm && $fell(unit_signal_pin_out));
endmodule
bind ccpu_unit ccpu_unit_props u_props (
   .mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .sixteen_bit_timebase,
   .timebase_clear, .period_timer, .period_tick, .period_timer_clear,
   .adc_enabled, .conv_start, .unit_signal_pin_out
);

/* tb_top.sv */
// self-checking testbench of the capture/compare/pwm unit
`timescale 1ns/10ps
module tb_top;
   logic        mclk, reset, reg_wr, reg_rd, ptick, ptc, tbc, adc, conv;
   logic        pin_in, pin_out, irq, run, load, ovf;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, ptimer, limit;
   logic [15:0] timebase, load_val;
   logic [1:0]  psub;
   int          n_fail, n_checks, tbc_n, conv_n;
   // clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // second-unit build, so the special event also starts a conversion
   ccpu_unit #(.IS_SECOND_UNIT(1'b1)) dut (
      .mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .sixteen_bit_timebase(timebase), .timebase_clear(tbc), .period_timer(ptimer),
      .period_sub(psub), .period_tick(ptick), .period_timer_clear(ptc),
      .adc_enabled(adc), .conv_start(conv), .unit_signal_pin_in(pin_in),
      .unit_signal_pin_out(pin_out), .unit_irq_request(irq));
   ccpu_timers_model tmr (.mclk, .reset, .run, .load, .load_val, .limit,
      .tb_clear(tbc), .pt_clear(ptc), .timebase, .ptimer, .psub, .ptick, .ovf);
   // count trigger pulses
   always @(posedge mclk) begin
      tbc_n  += int'(tbc === 1'b1);
      conv_n += int'(conv === 1'b1);
   end
   // ======================================
   // shared tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask
   task automatic setb(input logic [15:0] v, input logic r);
      @(posedge mclk);
      load     <= 1'b1;
      load_val <= v;
      run      <= r;
      @(posedge mclk);
      load <= 1'b0;
   endtask
   // each pulse drops the pin, then raises it
   task automatic rises(input int n);
      repeat (n) begin
         @(posedge mclk);
         pin_in <= 1'b0;
         repeat (2) @(posedge mclk);
         pin_in <= 1'b1;
         repeat (4) @(posedge mclk);
      end
   endtask
   // sync on a period start, count high cycles over one full period
   task automatic meas(input int exp_hi);
      int hi, k;
      hi = 0;
      k  = 0;
      #1;
      while (ptc !== 1'b1 && k < 200) begin
         @(posedge mclk);
         #1;
         k++;
      end
      if (k >= 200) begin
         n_fail++;
         $display("mismatch at %0t: period start not seen", $time);
         conclude;
      end
      repeat ((int'(limit) + 1) * 4) begin
         hi += int'(pin_out === 1'b1);
         @(posedge mclk);
         #1;
      end
      chk(16'(hi), 16'(exp_hi));
      chk(16'(ptc), 16'h0001);
   endtask
   // ======================================
   // scenarios
   task automatic t_reset;
      rd(4'h0, 8'h00);
      rd(4'h3, 8'hFF);
      rd(4'hF, 8'h00);
      chk(16'(pin_out), 16'h0000);
   endtask
   task automatic t_capture;
      setb(16'h1234, 1'b0);
      wr(4'h0, 8'h05);
      wr(4'h5, 8'h01);
      rd(4'h5, 8'h00);
      rises(1);
      rd(4'h1, 8'h34);
      rd(4'h2, 8'h12);
      rd(4'h5, 8'h01);
      setb(16'hABCD, 1'b0);
      rises(1);
      rd(4'h1, 8'hCD);
      wr(4'h0, 8'h04);
      setb(16'h0F0F, 1'b0);
      pin_in <= 1'b0;
      repeat (4) @(posedge mclk);
      rd(4'h2, 8'h0F);
   endtask
   task automatic t_presc;
      wr(4'h0, 8'h00);
      wr(4'h0, 8'h06);
      wr(4'h5, 8'h01);
      rises(3);
      rd(4'h6, 8'h30);
      rd(4'h5, 8'h00);
      rises(1);
      rd(4'h5, 8'h01);
      rises(2);
      wr(4'h0, 8'h07);
      rd(4'h6, 8'h20);
      wr(4'h0, 8'h00);
      rd(4'h6, 8'h00);
      wr(4'h0, 8'h07);
      wr(4'h5, 8'h01);
      rises(15);
      rd(4'h5, 8'h00);
      rises(1);
      rd(4'h5, 8'h01);
   endtask
   task automatic t_compare;
      logic [3:0] m [5] = '{4'h8, 4'hA, 4'hB, 4'hB, 4'h9};
      logic [4:0] p = 5'b01111;
      wr(4'h4, 8'h01);
      for (int i = 0; i < 5; i++) begin
         wr(4'h1, 8'h08);
         wr(4'h2, 8'h01);
         wr(4'h0, {4'h0, m[i]});
         wr(4'h5, 8'h01);
         tbc_n  = 0;
         conv_n = 0;
         // the second special event runs with the converter disabled
         adc    <= (i != 3);
         setb(16'h0100, 1'b1);
         repeat (20) @(posedge mclk);
         #1;
         chk(16'(pin_out), 16'(p[i]));
         chk(16'(irq), 16'h0001);
         chk(16'(tbc_n), 16'(m[i] == 4'hB));
         chk(16'(conv_n), 16'(m[i] == 4'hB && i != 3));
         chk(16'(ovf), 16'h0000);
      end
      wr(4'h0, 8'h08);
      setb(16'h0100, 1'b1);
      repeat (20) @(posedge mclk);
      #1;
      chk(16'(pin_out), 16'h0001);
      wr(4'h4, 8'h00);
      #1;
      chk(16'(irq), 16'h0000);
      wr(4'h0, 8'h00);
      repeat (2) @(posedge mclk);
      #1;
      chk(16'(pin_out), 16'h0000);
      rd(4'h6, 8'h00);
   endtask
   task automatic t_pwm;
      wr(4'h3, limit);
      wr(4'h1, 8'h03);
      wr(4'h0, 8'h2C);
      meas(15);
      rd(4'h2, 8'h03);
      wr(4'h1, 8'h05);
      rd(4'h2, 8'h03);
      meas(23);
      wr(4'h2, 8'h77);
      rd(4'h2, 8'h05);
      wr(4'h1, 8'h20);
      meas(40);
      wr(4'h0, 8'h00);
      repeat (2) @(posedge mclk);
      #1;
      chk(16'(pin_out), 16'h0000);
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h0C);
      meas(0);
   endtask
   // ======================================
   // main sequence
   initial begin
      {reset, reg_wr, reg_rd, pin_in, adc, run, load} = 7'b1000100;
      {reg_addr, reg_wdata, load_val} = 28'h0000000;
      limit    = 8'h09;
      n_fail   = 0;
      n_checks = 0;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      t_reset;
      t_capture;
      t_presc;
      t_compare;
      t_pwm;
      conclude;
   end
endmodule
